// File: tcs_regs.sv
`timescale 1ns/100ps
// How it works
// - Control bit7 chooses register or process mode
// - Bit6 zero reads, one writes register
// - Read places register value in input word
// - Write done only once acknowledgment returned
// - Six low bits address 64 registers
// - Status byte lowest, two data bytes follow
// - Read echoes control byte as status
// - Write answers address with bit7, bit6 cleared
// - Output word ignored on register read
// - Data word high byte first, low second
// - Process bit6 enables terminal compensation
// - Bit4 gain calibration, bit3 offset calibration
// - Bit2 picks step period; bits1/0 step
// - Calibration only after unlock code written
// - Permanent store only when code reset
// - Process status bit7 zero, bit6 error
// - Bits5:4 report limit 2 comparison
// - Bits3:2 report limit 1 comparison
// - Bit1 overrange, bit0 underrange
// - Register 9 returns firmware version ASCII
// - Register 8 returns type identifier
// - Registers protected except unlock code register; APB writes bypass the protection
module tcs_regs #(
    parameter int unsigned           STEP_SLOW = tcs_pkg::STEP_SLOW_CYC,  // Cycles per slow step
    parameter int unsigned           STEP_FAST = tcs_pkg::STEP_FAST_CYC,  // Cycles per fast step
    parameter logic [15:0]           TYPE_ID   = 16'h0100,                // Arbitrary value
    parameter logic [15:0]           FW_VER    = 16'h3030                 // Arbitrary value
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Process image
    input  wire logic                 image_valid,
    input  wire tcs_pkg::tcs_img_out_t img_out,
    output tcs_pkg::tcs_img_in_t      img_in,
    // Converter side
    input  wire logic [15:0]          meas_value,
    input  wire logic                 meas_overrange,
    input  wire logic                 meas_underrange,
    input  wire logic                 meas_error,
    // Calibration side
    output logic                      comp_enable,
    output logic                      cal_gain,
    output logic                      cal_offset,
    output logic                      cal_step_up,
    output logic                      cal_step_down,
    output logic                      nv_store
);

    localparam int CW = 25;  // Step counter width

    // Refuse step periods the counter cannot hold
    if (STEP_SLOW < 1 || STEP_FAST < 1 || STEP_SLOW >= (1 << CW) || STEP_FAST >= (1 << CW)) begin : g_chk
        $error("tcs_regs: step period out of range");
    end

    logic [15:0]  regs_q [64];      // Internal register set
    logic [1:0]   config_q;         // Bit0 image enable, bit1 forced error
    logic [7:0]   status_q;         // Returned status byte
    logic [15:0]  in_word_q;        // Returned input data word
    logic [7:0]   ctrl_seen_q;      // Last control byte taken
    logic         comp_q;           // Compensation enable
    logic         gain_q;           // Gain calibration active
    logic         offs_q;           // Offset calibration active
    logic         fast_q;           // Fast step period chosen
    logic         up_q;             // Step up request
    logic         down_q;           // Step down request
    logic         up_pulse_q;       // Step up pulse
    logic         down_pulse_q;     // Step down pulse
    logic         store_q;          // Permanent store pulse
    logic [CW-1:0] step_cnt_q;      // Step period counter
    logic [31:0]  prdata_q;         // APB read data
    logic         pready_q;         // APB answer
    logic         pslverr_q;        // APB error answer

    // Decoded image and APB fields, derived flags
    logic         img_take;         // Image exchange taken this cycle
    logic         is_reg;           // Register mode
    logic         is_wr;            // Register write
    logic [5:0]   idx;              // Register index
    logic         unlocked;         // Unlock code present
    logic         img_wr_ok;        // Image write allowed
    logic [15:0]  rd_val;           // Value read at idx
    logic [1:0]   lim1, lim2;       // Limit comparisons
    logic         apb_done;         // APB access completes
    logic         apb_reg_hit;      // APB address in register window
    logic [5:0]   apb_idx;          // APB register index
    logic         apb_map;          // APB address mapped
    logic         cal_on;           // Some calibration active
    logic         r31_wr;           // Any write to unlock register
    logic [15:0]  r31_new;          // Value written there

    assign img_take    = image_valid && config_q[0];
    assign is_reg      = img_out.ctrl[tcs_pkg::CTL_REG_BIT];
    assign is_wr       = img_out.ctrl[tcs_pkg::CTL_WRITE_BIT];
    assign idx         = img_out.ctrl[5:0];
    assign unlocked    = (regs_q[tcs_pkg::IDX_UNLOCK] == tcs_pkg::UNLOCK_CODE);
    // Protected unless unlocked; identity registers never writable
    assign img_wr_ok   = (idx == tcs_pkg::IDX_UNLOCK || unlocked) &&
                         idx != tcs_pkg::IDX_TYPE_ID && idx != tcs_pkg::IDX_FW_VER;
    assign apb_done    = psel && penable && pready_q;
    assign apb_reg_hit = paddr[11:8] == tcs_pkg::APB_REG_BASE[11:8] && paddr[1:0] == 2'h0;
    assign apb_idx     = paddr[7:2];
    assign apb_map     = apb_reg_hit || paddr == tcs_pkg::APB_STATUS ||
                         paddr == tcs_pkg::APB_CONFIG || paddr == tcs_pkg::APB_CAL;
    assign cal_on      = gain_q || offs_q;

    // Identity registers override the store
    always_comb begin
        unique case (idx)
            tcs_pkg::IDX_TYPE_ID: rd_val = TYPE_ID;
            tcs_pkg::IDX_FW_VER:  rd_val = FW_VER;
            default:              rd_val = regs_q[idx];
        endcase
    end

    // Limit comparison, signed against process value
    always_comb begin
        lim1 = tcs_pkg::LIM_OFF;
        lim2 = tcs_pkg::LIM_OFF;
        if (regs_q[tcs_pkg::IDX_FEATURE][tcs_pkg::FEAT_LIM1_EN]) begin
            if ($signed(meas_value) < $signed(regs_q[tcs_pkg::IDX_LIMIT1])) lim1 = tcs_pkg::LIM_BELOW;
            else if ($signed(meas_value) > $signed(regs_q[tcs_pkg::IDX_LIMIT1])) lim1 = tcs_pkg::LIM_ABOVE;
            else lim1 = tcs_pkg::LIM_EQUAL;
        end
        if (regs_q[tcs_pkg::IDX_FEATURE][tcs_pkg::FEAT_LIM2_EN]) begin
            if ($signed(meas_value) < $signed(regs_q[tcs_pkg::IDX_LIMIT2])) lim2 = tcs_pkg::LIM_BELOW;
            else if ($signed(meas_value) > $signed(regs_q[tcs_pkg::IDX_LIMIT2])) lim2 = tcs_pkg::LIM_ABOVE;
            else lim2 = tcs_pkg::LIM_EQUAL;
        end
    end

    // Who writes the unlock register this cycle, image first
    always_comb begin
        r31_wr  = 1'b0;
        r31_new = regs_q[tcs_pkg::IDX_UNLOCK];
        if (img_take && is_reg && is_wr && idx == tcs_pkg::IDX_UNLOCK) begin
            r31_wr  = 1'b1;
            r31_new = img_out.data_word;
        end else if (!(img_take && is_reg && is_wr) && apb_done && pwrite && apb_reg_hit &&
                     apb_idx == tcs_pkg::IDX_UNLOCK) begin
            // Any image write blocks the bus write, as in the register set
            r31_wr  = 1'b1;
            r31_new = pwdata[15:0];
        end
    end

    // Register set; image write wins over APB in the same cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 64; i++) regs_q[i] <= tcs_pkg::REG_RST_VAL;
        end else if (img_take && is_reg && is_wr) begin
            if (img_wr_ok) regs_q[idx] <= img_out.data_word;
        end else if (apb_done && pwrite && apb_reg_hit) begin
            // Local firmware path, not subject to write protection
            regs_q[apb_idx] <= pwdata[15:0];
        end
    end

    // Answer to the coupler
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_q    <= 8'h00;
            in_word_q   <= 16'h0000;
            ctrl_seen_q <= 8'h00;
        end else if (img_take) begin
            ctrl_seen_q <= img_out.ctrl;
            if (is_reg && is_wr) begin
                // Acknowledge: address with register bit, write bit cleared
                status_q <= {1'b1, 1'b0, idx};
                // Input word is meaningless after a write; left as it was
            end else if (is_reg) begin
                status_q  <= img_out.ctrl;
                in_word_q <= rd_val;
            end else begin
                status_q  <= {1'b0, meas_error || config_q[1], lim2, lim1,
                              meas_overrange, meas_underrange};
                in_word_q <= meas_value;
            end
        end
    end

    // Process mode control bits; calibration needs the unlock code
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            comp_q <= 1'b0;
            gain_q <= 1'b0;
            offs_q <= 1'b0;
            fast_q <= 1'b0;
            up_q   <= 1'b0;
            down_q <= 1'b0;
        end else if (img_take && !is_reg) begin
            comp_q <= img_out.ctrl[tcs_pkg::CTL_COMP_BIT];
            gain_q <= img_out.ctrl[tcs_pkg::CTL_GAIN_BIT] && unlocked;
            offs_q <= img_out.ctrl[tcs_pkg::CTL_OFFS_BIT] && unlocked;
            fast_q <= img_out.ctrl[tcs_pkg::CTL_FAST_BIT];
            up_q   <= img_out.ctrl[tcs_pkg::CTL_UP_BIT];
            down_q <= img_out.ctrl[tcs_pkg::CTL_DOWN_BIT];
        end else if (!unlocked) begin
            // Relocking ends any calibration at once
            gain_q <= 1'b0;
            offs_q <= 1'b0;
        end
    end

    // Step timer: one step per period while calibrating
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_cnt_q   <= '0;
            up_pulse_q   <= 1'b0;
            down_pulse_q <= 1'b0;
        end else begin
            up_pulse_q   <= 1'b0;
            down_pulse_q <= 1'b0;
            if (!cal_on) begin
                step_cnt_q <= '0;
            end else if (step_cnt_q == '0) begin
                // Period reloaded from the current speed choice
                step_cnt_q   <= fast_q ? CW'(STEP_FAST - 1) : CW'(STEP_SLOW - 1);
                up_pulse_q   <= up_q;
                down_pulse_q <= down_q;
            end else begin
                step_cnt_q <= step_cnt_q - 1'b1;
            end
        end
    end

    // Store pulse when the code word is taken away
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            store_q <= 1'b0;
        end else begin
            store_q <= unlocked && r31_wr && r31_new != tcs_pkg::UNLOCK_CODE;
        end
    end

    // APB slave, one wait state; error on unmapped address
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            config_q  <= tcs_pkg::CONFIG_RST;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !apb_map;
            if (psel && penable && !pready_q) begin
                if (apb_reg_hit) begin
                    unique case (apb_idx)
                        tcs_pkg::IDX_TYPE_ID: prdata_q <= {16'h0000, TYPE_ID};
                        tcs_pkg::IDX_FW_VER:  prdata_q <= {16'h0000, FW_VER};
                        default:              prdata_q <= {16'h0000, regs_q[apb_idx]};
                    endcase
                end else if (paddr == tcs_pkg::APB_STATUS) begin
                    prdata_q <= {16'h0000, ctrl_seen_q, status_q};
                end else if (paddr == tcs_pkg::APB_CONFIG) begin
                    prdata_q <= {30'h0, config_q};
                end else if (paddr == tcs_pkg::APB_CAL) begin
                    prdata_q <= {26'h0, unlocked, fast_q, offs_q, gain_q, comp_q, cal_on};
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end
            if (apb_done && pwrite && paddr == tcs_pkg::APB_CONFIG) config_q <= pwdata[1:0];
        end
    end

    // Outputs straight from flip-flops
    assign img_in        = {status_q, in_word_q};
    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign comp_enable   = comp_q;
    assign cal_gain      = gain_q;
    assign cal_offset    = offs_q;
    assign cal_step_up   = up_pulse_q;
    assign cal_step_down = down_pulse_q;
    assign nv_store      = store_q;

    // Helper: previous unlock state, for the calibration lock check
    logic        was_unlocked_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) was_unlocked_q <= 1'b0;
        else         was_unlocked_q <= unlocked;
    end

    write_ack_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        img_take && is_reg && is_wr |=> status_q == {2'h2, $past(idx)})
        else $error("write acknowledgment wrong");

    read_echo_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        img_take && is_reg && !is_wr |=> status_q == $past(img_out.ctrl))
        else $error("read receipt not an echo");

    read_data_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        img_take && is_reg && !is_wr |=> in_word_q == $past(rd_val))
        else $error("read data wrong");

    type_id_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        img_take && img_out.ctrl == {2'h2, tcs_pkg::IDX_TYPE_ID} |=> in_word_q == TYPE_ID)
        else $error("type identifier wrong");

    proc_status_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        img_take && !is_reg |=> !status_q[7] && status_q[1:0] == $past({meas_overrange, meas_underrange}))
        else $error("process status wrong");

    protect_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        img_take && is_reg && is_wr && !unlocked && idx != tcs_pkg::IDX_UNLOCK
        |=> regs_q[$past(idx)] == $past(regs_q[idx]))
        else $error("protected register changed");

    cal_lock_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (gain_q || offs_q) |-> was_unlocked_q)
        else $error("calibration while locked");

    store_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        store_q |-> $past(unlocked) && !unlocked ##1 !store_q)
        else $error("store pulse wrong");

    step_fast_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        cal_on && fast_q && step_cnt_q == '0 && up_q |=> up_pulse_q)
        else $error("step pulse missing");

endmodule

// File: tcs_pkg.sv
package tcs_pkg;

    // Process image bit positions of the control byte
    localparam int CTL_REG_BIT    = 7;  // Register mode select
    localparam int CTL_WRITE_BIT  = 6;  // Write direction in register mode
    localparam int CTL_COMP_BIT   = 6;  // Compensation enable in process mode
    localparam int CTL_GAIN_BIT   = 4;  // Gain calibration select
    localparam int CTL_OFFS_BIT   = 3;  // Offset calibration select
    localparam int CTL_FAST_BIT   = 2;  // Fast adjustment step period
    localparam int CTL_UP_BIT     = 1;  // Step value up
    localparam int CTL_DOWN_BIT   = 0;  // Step value down

    // Internal register indices and fields
    localparam logic [5:0]  IDX_TYPE_ID  = 6'h08;  // Type identifier, read only
    localparam logic [5:0]  IDX_FW_VER   = 6'h09;  // Firmware version, read only
    localparam logic [5:0]  IDX_UNLOCK   = 6'h1f;  // Unlock code word register
    localparam logic [5:0]  IDX_FEATURE  = 6'h20;  // Feature register
    localparam logic [5:0]  IDX_LIMIT1   = 6'h23;  // Limit value 1
    localparam logic [5:0]  IDX_LIMIT2   = 6'h24;  // Limit value 2
    localparam int          FEAT_LIM1_EN = 9;      // Feature bit: limit 1 active
    localparam int          FEAT_LIM2_EN = 10;     // Feature bit: limit 2 active
    localparam logic [15:0] UNLOCK_CODE  = 16'h1235;
    localparam logic [15:0] REG_RST_VAL  = 16'h0000;

    // Limit comparison encoding
    localparam logic [1:0] LIM_OFF   = 2'h0;
    localparam logic [1:0] LIM_BELOW = 2'h1;
    localparam logic [1:0] LIM_ABOVE = 2'h2;
    localparam logic [1:0] LIM_EQUAL = 2'h3;

    // Calibration step periods, in ms, and the clock in kHz
    localparam int unsigned CLK_KHZ      = 25000;
    localparam int unsigned STEP_SLOW_MS = 1000;
    localparam int unsigned STEP_FAST_MS = 50;
    localparam int unsigned STEP_SLOW_CYC = STEP_SLOW_MS * CLK_KHZ;
    localparam int unsigned STEP_FAST_CYC = STEP_FAST_MS * CLK_KHZ;

    // APB byte addresses
    localparam logic [11:0] APB_STATUS   = 12'h000;  // Last status and control bytes
    localparam logic [11:0] APB_CONFIG   = 12'h004;  // Error force and image enable
    localparam logic [11:0] APB_CAL      = 12'h008;  // Calibration state
    localparam logic [11:0] APB_REG_BASE = 12'h100;  // 64 words of internal registers
    localparam logic [1:0]  CONFIG_RST   = 2'h1;     // Image handling enabled

    // Image from the coupler and answer to it
    typedef struct packed {
        logic [7:0]  ctrl;       // Control byte, lowest byte of the channel
        logic [15:0] data_word;  // Output data word, high byte first
    } tcs_img_out_t;

    typedef struct packed {
        logic [7:0]  status;     // Status byte
        logic [15:0] data_word;  // Input data word, high byte first
    } tcs_img_in_t;

endpackage

// File: tcs_coupler_model.sv
`timescale 1ns/100ps
// Coupler end of the image; one request held until answered
module tcs_coupler_model (
    // Clock
    input  wire logic                 core_clk,
    // Image lines
    output logic                      image_valid,
    output tcs_pkg::tcs_img_out_t     img_out,
    input  wire tcs_pkg::tcs_img_in_t img_in,
    // Set when an answer never came
    output logic                      lost
);
    initial begin
        image_valid = 1'b0;
        img_out     = '0;
        lost        = 1'b0;
    end

    // Called just after a rising edge; lines stay put after the strobe
    task automatic xfer(input logic [7:0] ctl, input logic [15:0] wd,
                        output logic [7:0] st, output logic [15:0] dw);
        int n;
        n = 0;
        image_valid <= 1'b1;
        img_out     <= {ctl, wd};
        @(posedge core_clk);
        image_valid <= 1'b0;
        // Register mode waits for its own address in the status byte
        do begin
            @(posedge core_clk);
            n++;
        end while (ctl[7] && img_in.status[5:0] !== ctl[5:0] && n < 8);
        lost |= (n == 8);
        st = img_in.status;
        dw = img_in.data_word;
    endtask
endmodule

// File: terminal_control_status_register_access_bench.sv
`timescale 1ns/100ps
// Image and APB traffic checked against an integer register model
module terminal_control_status_register_access_bench;
    localparam int          SLOW = 20;        // Shortened slow step
    localparam int          FAST = 4;         // Shortened fast step
    localparam logic [15:0] TID  = 16'h0c5a;  // Arbitrary value
    localparam logic [15:0] FWV  = 16'h3137;  // Arbitrary value
    logic                   core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, rd;
    logic                   image_valid, meas_overrange, meas_underrange, meas_error, lost;
    logic [15:0]            meas_value, dw;
    logic [7:0]             st;
    logic                   comp_enable, cal_gain, cal_offset, cal_step_up, cal_step_down, nv_store;
    tcs_pkg::tcs_img_out_t  img_out;
    tcs_pkg::tcs_img_in_t   img_in;
    int                     num_errors, cmp_count, nv_count, seed, model[64];
    bit                     unlocked;

    tcs_regs #(.STEP_SLOW(SLOW), .STEP_FAST(FAST), .TYPE_ID(TID), .FW_VER(FWV)) u_tcs_regs (
        .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .image_valid, .img_out, .img_in, .meas_value, .meas_overrange, .meas_underrange,
        .meas_error, .comp_enable, .cal_gain, .cal_offset, .cal_step_up, .cal_step_down, .nv_store);
    tcs_coupler_model u_tcs_coupler_model (.core_clk, .image_valid, .img_out, .img_in, .lost);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Store pulses, counted for the lock sequence
    always @(posedge core_clk) if (nv_store === 1'b1) nv_count++;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One APB transfer; a lost pready ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge core_clk);
        if (n == 16) begin
            num_errors++;
            test_done();
        end
    endtask

    // APB path goes past the write protection
    task automatic regw(input int i, input logic [15:0] v);
        apb(1'b1, 12'h100 + 12'(4 * i), {16'h0, v});
        model[i] = v;
    endtask

    task automatic rd_img(input int i);
        u_tcs_coupler_model.xfer(8'h80 | 8'(i), 16'($random(seed)), st, dw);
        chk("read status", st, 8'h80 | 8'(i));
        chk("read word", dw, model[i][15:0]);
    endtask

    task automatic wr_img(input int i, input logic [15:0] v);
        u_tcs_coupler_model.xfer(8'hc0 | 8'(i), v, st, dw);
        chk("write ack", st, 8'h80 | 8'(i));
        if (i == 31)
            unlocked = (v == tcs_pkg::UNLOCK_CODE);
        if (i == 31 || (unlocked && i != 8 && i != 9))
            model[i] = v;
    endtask

    // Cycles between two step pulses of one direction
    task automatic gap(input int period, input bit up);
        int n;
        n = 0;
        while ((up ? cal_step_up : cal_step_down) !== 1'b1 && n < 64) begin
            @(posedge core_clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while ((up ? cal_step_up : cal_step_down) !== 1'b1 && n < 64);
        chk("step period", n, period);
    endtask

    // Signed limit comparison code
    function automatic logic [1:0] lim(input logic signed [15:0] v, input logic signed [15:0] l, input logic en);
        if (!en)
            return 2'h0;
        if (v < l)
            return 2'h1;
        return (v > l) ? 2'h2 : 2'h3;
    endfunction

    initial begin
        logic [15:0] l1, l2, ft;
        logic [7:0]  ex;
        int          idx;
        seed = 80571;
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {meas_value, meas_overrange, meas_underrange, meas_error} = '0;
        foreach (model[i]) model[i] = 0;
        model[8] = TID;
        model[9] = FWV;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk("reset image", img_in, 24'h0);
        apb(1'b0, tcs_pkg::APB_CONFIG, 32'h0);
        chk("config reset", rd, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped error", er, 1'b1);
        regw(40, 16'h5a5a);
        apb(1'b0, 12'h1a0, 32'h0);
        chk("apb reg read", rd, 32'h0000_5a5a);
        rd_img(8);
        rd_img(9);
        rd_img(40);
        apb(1'b0, tcs_pkg::APB_STATUS, 32'h0);
        chk("status mirror", rd, 32'h0000_a8a8);
        // Random accesses, first locked then unlocked
        for (int i = 0; i < 24; i++) begin
            idx = $unsigned($random(seed)) % 64;
            if (idx == 31)
                idx = 30;
            if (i == 12) begin
                u_tcs_coupler_model.xfer(8'h56, 16'h0, st, dw);
                chk("locked gain", cal_gain, 1'b0);
                wr_img(31, tcs_pkg::UNLOCK_CODE);
            end
            if ($random(seed) & 1)
                wr_img(idx, 16'($random(seed)));
            else
                rd_img(idx);
        end
        rd_img(31);
        // Calibration while unlocked
        u_tcs_coupler_model.xfer(8'h56, 16'h0, st, dw);
        chk("comp enable", comp_enable, 1'b1);
        chk("gain select", {cal_gain, cal_offset}, 2'h2);
        apb(1'b0, tcs_pkg::APB_CAL, 32'h0);
        chk("cal state", rd, 32'h0000_0037);
        gap(FAST, 1'b1);
        u_tcs_coupler_model.xfer(8'h09, 16'h0, st, dw);
        chk("offset select", {cal_gain, cal_offset}, 2'h1);
        gap(SLOW, 1'b0);
        chk("no early store", nv_count, 0);
        wr_img(31, 16'h0);
        for (int n = 0; n < 8 && nv_count == 0; n++) @(posedge core_clk);
        chk("store on lock", nv_count, 1);
        // Process mode status over limit and range cases
        for (int i = 0; i < 6; i++) begin
            l1 = 16'($random(seed));
            l2 = 16'($random(seed));
            ft = (i == 0) ? 16'h0 : 16'h0600;
            regw(32, ft);
            regw(35, l1);
            regw(36, l2);
            apb(1'b1, tcs_pkg::APB_CONFIG, {30'h0, i == 4, 1'b1});
            meas_value      <= (i == 2) ? l1 : (i == 3) ? l2 : 16'($random(seed));
            meas_overrange  <= i[0];
            meas_underrange <= i[1];
            meas_error      <= (i == 5);
            u_tcs_coupler_model.xfer(8'h00, 16'($random(seed)), st, dw);
            ex = {1'b0, meas_error | (i == 4), lim(meas_value, l2, ft[10]), lim(meas_value, l1, ft[9]),
                  meas_overrange, meas_underrange};
            chk("process status", st, ex);
            chk("process word", dw, meas_value);
        end
        chk("answer lost", lost, 1'b0);
        test_done();
    end
endmodule
